// ---- verilog/upmc_defines.svh ----
// Constants for the USB power mode control block
// Assumes inclusion by the package, the top module and the checker only
`ifndef UPMC_DEFINES_SVH
`define UPMC_DEFINES_SVH
`define UPMC_PWR_ON_BIT      0
`define UPMC_SUSPEND_BIT     1
`define UPMC_GUARD_BIT       4
`define UPMC_ACTPND_BIT      7
`define UPMC_AUTO_SUSP_BIT   0
`define UPMC_EYE_BIT         7
`define UPMC_LINE_SE0        2'h0
`define UPMC_LINE_J          2'h1
`define UPMC_LINE_K          2'h2
`define UPMC_RST_PWRC        8'h00
`define UPMC_RST_CNFG1       8'h00
`endif

// ---- verilog/upmc_pkg.sv ----
// Types for the USB power mode control block
// Assumes the defines header sits beside it
`include "upmc_defines.svh"
package upmc_pkg;
    typedef enum logic [1:0] {
        UPMC_RUN   = 2'b00,
        UPMC_IDLE  = 2'b01,
        UPMC_SLEEP = 2'b10
    } upmc_cpu_mode_t;
    typedef logic [1:0] upmc_line_t;
endpackage

// ---- verilog/upmc_usb_power_mode_control.sv ----
// Power mode control for the USB module: clock and oscillator gating,
// suspend, sleep guard, eye pattern transmitter and reset defaults.
// Assumes synchronous inputs on clk and a CPU power manager that
// requests Sleep or Idle on cpu_mode_req and honours the wake and block outputs.
//
// How it works
// [RULE_01] Sleep keeps USB module clock running
// [RULE_02] Shared oscillator: CPU cut, oscillator kept
// [RULE_03] Separate source: CPU source off, USB kept
// [RULE_04] Suspend request bit suspends module
// [RULE_05] Auto suspend bit suspends on Sleep
// [RULE_06] Suspended and shared: oscillator off in Sleep
// [RULE_07] Not shared: oscillator off on suspend
// [RULE_08] Guard bit turns activity into wake event
// [RULE_09] Software polls pending flag before Sleep
// [RULE_10] Pending flag set and cleared by hardware
// [RULE_11] Idle, stop clear: only CPU clock gated
// [RULE_12] Idle, stop clear: enabled interrupt wakes CPU
// [RULE_13] Idle, stop set: CPU and USB gated
// [RULE_14] Gated Idle: bus activity wakes CPU
// [RULE_15] Software uses fast RC only on idle bus
// [RULE_16] Eye bit sends endless J-K pattern
// [RULE_17] Eye pattern needs power, clock, no suspend/freeze
// [RULE_18] Software never runs eye test live
// [RULE_19] Software sleeps only when disabled or suspended
// [RULE_20] Every reset restores register defaults
// [RULE_21] Descriptor table and buffers undefined after reset
// [RULE_22] Clearing eye bit returns line to idle
`timescale 1ns/1ps
`include "upmc_defines.svh"

module upmc_usb_power_mode_control (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Register writes from the CPU
    input  wire logic                    pwrc_wr,
    input  wire logic [7:0]              pwrc_wdata,
    input  wire logic                    cnfg1_wr,
    input  wire logic [7:0]              cnfg1_wdata,
    // CPU power manager
    input  wire upmc_pkg::upmc_cpu_mode_t cpu_mode_req,
    input  wire logic                    stop_in_idle_bit,
    input  wire logic                    osc_shared,
    input  wire logic                    freeze,
    input  wire logic                    clk48_en,
    // USB side events
    input  wire logic                    bus_activity,
    input  wire logic                    usb_irq_enabled,
    // Register readback
    output logic [7:0]                   pwrc_rdata,
    output logic [7:0]                   cnfg1_rdata,
    // Clock and oscillator controls
    output logic                         cpu_clk_en,
    output logic                         usb_clk_en,
    output logic                         posc_en,
    output logic                         cpu_src_en,
    output logic                         usb_suspended,
    // Wake and guard
    output logic                         wake_event,
    output logic                         sleep_blocked,
    // Eye pattern line
    output upmc_pkg::upmc_line_t         tx_line,
    output logic                         tx_oe
);
    import upmc_pkg::*;

    logic       rst_s1_r;
    logic       rst_s2_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    logic [7:0]     pwrc_r, pwrc_nxt;
    logic [7:0]     cnfg1_r, cnfg1_nxt;
    logic           cpu_clk_en_r, cpu_clk_en_nxt;
    logic           usb_clk_en_r, usb_clk_en_nxt;
    logic           posc_en_r, posc_en_nxt;
    logic           cpu_src_en_r, cpu_src_en_nxt;
    logic           susp_r, susp_nxt;
    logic           wake_r, wake_nxt;
    logic           blocked_r, blocked_nxt;
    upmc_line_t     line_r, line_nxt;
    logic           oe_r, oe_nxt;
    logic           sleeping, idling, guard, pending, eye_ok;

    always_comb begin
        sleeping = (cpu_mode_req == UPMC_SLEEP);
        idling   = (cpu_mode_req == UPMC_IDLE);
        pwrc_nxt  = pwrc_r;
        cnfg1_nxt = cnfg1_r;
        if (pwrc_wr) begin
            pwrc_nxt = pwrc_wdata;
            // [RULE_10] Pending flag hardware only
            pwrc_nxt[`UPMC_ACTPND_BIT] = pwrc_r[`UPMC_ACTPND_BIT];
        end
        if (cnfg1_wr) begin
            cnfg1_nxt = cnfg1_wdata;
        end
        guard = pwrc_r[`UPMC_GUARD_BIT];
        // [RULE_10] Set on activity, cleared when quiet
        pending = bus_activity;
        pwrc_nxt[`UPMC_ACTPND_BIT] = pending;

        // [RULE_04] Software suspend request
        // [RULE_05] Automatic suspend on Sleep
        susp_nxt = pwrc_r[`UPMC_SUSPEND_BIT]
                   | (cnfg1_r[`UPMC_AUTO_SUSP_BIT] & sleeping);

        // [RULE_08] Guard blocks Sleep with wake event
        blocked_nxt = guard & sleeping & (bus_activity | pwrc_r[`UPMC_ACTPND_BIT]);
        wake_nxt    = blocked_nxt;
        if (idling) begin
            // [RULE_12] Enabled interrupt ends Idle
            if (!stop_in_idle_bit && usb_irq_enabled) begin
                wake_nxt = 1'b1;
            end
            // [RULE_14] Bus activity ends gated Idle
            if (stop_in_idle_bit && bus_activity) begin
                wake_nxt = 1'b1;
            end
        end

        cpu_clk_en_nxt = 1'b1;
        usb_clk_en_nxt = 1'b1;
        posc_en_nxt    = 1'b1;
        cpu_src_en_nxt = 1'b1;
        if (sleeping && !blocked_nxt) begin
            // [RULE_01] USB clock kept in Sleep
            cpu_clk_en_nxt = 1'b0;
            if (osc_shared) begin
                // [RULE_02] Oscillator kept for USB
                // [RULE_06] Off once suspended
                posc_en_nxt = !susp_nxt;
                usb_clk_en_nxt = !susp_nxt;
            end else begin
                // [RULE_03] CPU source off, USB source kept
                cpu_src_en_nxt = 1'b0;
            end
        end else if (idling) begin
            // [RULE_11] Only CPU clock gated
            cpu_clk_en_nxt = 1'b0;
            // [RULE_13] USB clock gated too
            usb_clk_en_nxt = !stop_in_idle_bit;
        end
        if (!osc_shared && susp_nxt) begin
            // [RULE_07] Unshared oscillator off on suspend
            posc_en_nxt    = 1'b0;
            usb_clk_en_nxt = 1'b0;
        end

        // [RULE_17] Eye pattern preconditions
        eye_ok = cnfg1_r[`UPMC_EYE_BIT] & pwrc_r[`UPMC_PWR_ON_BIT] & clk48_en
                 & !pwrc_r[`UPMC_SUSPEND_BIT] & !freeze;
        if (eye_ok) begin
            // [RULE_16] Alternate J and K without end
            line_nxt = (line_r == `UPMC_LINE_J) ? `UPMC_LINE_K : `UPMC_LINE_J;
            oe_nxt   = 1'b1;
        end else begin
            // [RULE_22] Back to idle J, released
            line_nxt = `UPMC_LINE_J;
            oe_nxt   = 1'b0;
        end
    end

    // [RULE_20] Every reset restores defaults
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            pwrc_r       <= `UPMC_RST_PWRC;
            cnfg1_r      <= `UPMC_RST_CNFG1;
            cpu_clk_en_r <= 1'b1;
            usb_clk_en_r <= 1'b1;
            posc_en_r    <= 1'b1;
            cpu_src_en_r <= 1'b1;
            susp_r       <= 1'b0;
            wake_r       <= 1'b0;
            blocked_r    <= 1'b0;
            line_r       <= `UPMC_LINE_J;
            oe_r         <= 1'b0;
        end else begin
            pwrc_r       <= pwrc_nxt;
            cnfg1_r      <= cnfg1_nxt;
            cpu_clk_en_r <= cpu_clk_en_nxt;
            usb_clk_en_r <= usb_clk_en_nxt;
            posc_en_r    <= posc_en_nxt;
            cpu_src_en_r <= cpu_src_en_nxt;
            susp_r       <= susp_nxt;
            wake_r       <= wake_nxt;
            blocked_r    <= blocked_nxt;
            line_r       <= line_nxt;
            oe_r         <= oe_nxt;
        end
    end

    assign pwrc_rdata    = pwrc_r;
    assign cnfg1_rdata   = cnfg1_r;
    assign cpu_clk_en    = cpu_clk_en_r;
    assign usb_clk_en    = usb_clk_en_r;
    assign posc_en       = posc_en_r;
    assign cpu_src_en    = cpu_src_en_r;
    assign usb_suspended = susp_r;
    assign wake_event    = wake_r;
    assign sleep_blocked = blocked_r;
    assign tx_line       = line_r;
    assign tx_oe         = oe_r;

endmodule // upmc_usb_power_mode_control

// ---- tb/upmc_properties.sv ----
// Checker for the USB power mode control block
// Assumes bind onto the top module and sight of its ports only
`timescale 1ns/1ps
`include "upmc_defines.svh"
module upmc_properties (
    // Inputs and outputs of the block
    input wire logic clk, rst_n, stop_in_idle_bit, osc_shared, freeze, clk48_en,
    input wire logic bus_activity, usb_irq_enabled, cpu_clk_en, usb_clk_en, posc_en,
    input wire logic cpu_src_en, usb_suspended, wake_event, sleep_blocked, tx_oe,
    input wire logic [7:0] pwrc_rdata, cnfg1_rdata,
    input wire upmc_pkg::upmc_cpu_mode_t cpu_mode_req,
    input wire upmc_pkg::upmc_line_t tx_line
);
    import upmc_pkg::*;
    wire slp = cpu_mode_req == UPMC_SLEEP && !pwrc_rdata[4];
    wire idl = cpu_mode_req == UPMC_IDLE && !pwrc_rdata[1];
    wire eye = cnfg1_rdata[7] && pwrc_rdata[0] && clk48_en && !pwrc_rdata[1] && !freeze;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence tx_two; tx_oe ##1 tx_oe; endsequence
    sleep_shared_a: assert property (
        slp && osc_shared && !pwrc_rdata[1] && !cnfg1_rdata[0] |=> !cpu_clk_en && posc_en
        && usb_clk_en) else $error("bad sleep clocks");
    susp_req_a: assert property (
        pwrc_rdata[1] |=> usb_suspended) else $error("no suspend");
    split_off_a: assert property (
        !osc_shared && pwrc_rdata[1] |=> !posc_en) else $error("oscillator kept");
    guard_wake_a: assert property (
        cpu_mode_req == UPMC_SLEEP && pwrc_rdata[4] && bus_activity |=> wake_event
        && sleep_blocked && cpu_clk_en) else $error("guard failed");
    pend_hw_a: assert property (
        1 |=> pwrc_rdata[7] == $past(bus_activity)) else $error("bad pending flag");
    idle_clk_a: assert property (
        idl |=> !cpu_clk_en && usb_clk_en == !$past(stop_in_idle_bit)) else $error("bad idle");
    idle_wake_a: assert property (
        idl && (stop_in_idle_bit ? bus_activity : usb_irq_enabled) |=> wake_event)
        else $error("no idle wake");
    eye_run_a: assert property (
        eye |=> tx_oe) else $error("no eye pattern");
    eye_alt_a: assert property (
        tx_two |-> tx_line != $past(tx_line)) else $error("eye not toggling");
    eye_stop_a: assert property (
        !eye |=> !tx_oe && tx_line == `UPMC_LINE_J) else $error("eye not idle");
endmodule // upmc_properties

// ---- tb/upmc_power_manager_model.sv ----
// Partner model: CPU power manager and USB bus peer
// Assumes the bench asks for a mode and bus activity on clk
`timescale 1ns/1ps
module upmc_power_manager_model (
    input  wire logic                     clk,
    input  wire upmc_pkg::upmc_cpu_mode_t want_mode,
    input  wire logic                     want_act,
    input  wire logic                     pending,
    output upmc_pkg::upmc_cpu_mode_t      cpu_mode_req,
    output logic                          bus_activity
);
    import upmc_pkg::*;
    initial cpu_mode_req = UPMC_RUN;
    initial bus_activity = 1'b0;
    always @(posedge clk) begin
        #1;
        // Sleep entry only with pending flag clear
        if (!(want_mode == UPMC_SLEEP && cpu_mode_req != UPMC_SLEEP && pending))
            cpu_mode_req = want_mode;
        bus_activity = want_act;
    end
endmodule // upmc_power_manager_model

// ---- tb/upmc_usb_power_mode_control_test.sv ----
// Testbench for the USB power mode control block
// Assumes design, checker and partner model compiled before it
`timescale 1ns/1ps
module upmc_usb_power_mode_control_test;
    import upmc_pkg::*;
    logic clk = 0, rst_n = 0, pwrc_wr = 0, cnfg1_wr = 0, stop_in_idle_bit = 0, freeze = 0;
    logic osc_shared = 1, clk48_en = 1, usb_irq_enabled = 0, want_act = 0, bus_activity;
    logic cpu_clk_en, usb_clk_en, posc_en, cpu_src_en, usb_suspended, wake_event;
    logic sleep_blocked, tx_oe;
    logic [7:0] pwrc_wdata = 0, cnfg1_wdata = 0, pwrc_rdata, cnfg1_rdata;
    logic [31:0] notes[$], note, r;
    upmc_line_t tx_line;
    upmc_cpu_mode_t want_mode = UPMC_RUN, cpu_mode_req;
    int mismatches = 0, tests_run = 0;
    upmc_usb_power_mode_control upmc_usb_power_mode_control_i (.*);
    upmc_power_manager_model upmc_power_manager_model_i (.clk, .want_mode, .want_act,
        .pending(pwrc_rdata[7]), .cpu_mode_req, .bus_activity);
    wire [15:0] obs = {cpu_clk_en, usb_clk_en, posc_en, cpu_src_en, usb_suspended,
        wake_event, sleep_blocked, tx_oe, pwrc_rdata};
    initial forever #2.5 clk = ~clk;
    task step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(logic p, logic [7:0] d);
        {pwrc_wr, cnfg1_wr, pwrc_wdata, cnfg1_wdata} = {p, !p, d, d};
        step(1);
        {pwrc_wr, cnfg1_wr} = 2'h0;
        step(1);
    endtask
    task chk(logic [15:0] m, logic [15:0] v);
        step(3);
        notes.push_back({m, v});
        step(1);
        $display("test ended at %0t", $time);
    endtask
    always @(negedge clk) begin
        if (notes.size() > 0) begin
            note = notes.pop_front();
            tests_run++;
            if ((obs & note[31:16]) !== note[15:0]) begin
                mismatches++;
                $display("unexpected at %0t: %h vs %h", $time, obs & note[31:16], note[15:0]);
            end
        end
    end
    task report_and_stop;
        $display("compared %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #15000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'he8d580f9));
        step(20);
        rst_n = 1;
        chk(16'hffff, 16'hf000);
        r = $urandom;
        wr(1, {1'b1, r[6:0]});
        chk(16'h0093, {8'h00, r[7:0] & 8'h13});
        wr(1, 8'h01);
        want_mode = UPMC_SLEEP;
        chk(16'he000, 16'h6000);
        osc_shared = 0;
        chk(16'h5000, 16'h4000);
        want_mode = UPMC_RUN;
        wr(1, 8'h03);
        chk(16'h2800, 16'h0800);
        osc_shared = 1;
        want_mode = UPMC_SLEEP;
        chk(16'h2000, 16'h0000);
        want_mode = UPMC_RUN;
        wr(1, 8'h01);
        wr(0, 8'h01);
        want_mode = UPMC_SLEEP;
        chk(16'h0800, 16'h0800);
        want_mode = UPMC_RUN;
        wr(0, 8'h00);
        wr(1, 8'h11);
        {want_mode, want_act} = {UPMC_SLEEP, 1'b1};
        chk(16'h8680, 16'h8680);
        {want_mode, want_act, usb_irq_enabled} = {UPMC_RUN, 2'h1};
        wr(1, 8'h01);
        want_mode = UPMC_IDLE;
        chk(16'hc400, 16'h4400);
        {usb_irq_enabled, stop_in_idle_bit, want_act} = 3'h3;
        chk(16'hc400, 16'h0400);
        {want_mode, want_act, stop_in_idle_bit} = {UPMC_RUN, 2'h0};
        // Eye test on a quiet bus
        wr(0, 8'h80);
        chk(16'h0100, 16'h0100);
        freeze = 1;
        chk(16'h0100, 16'h0000);
        {freeze, clk48_en} = 2'h0;
        chk(16'h0100, 16'h0000);
        clk48_en = 1;
        wr(0, 8'h00);
        chk(16'h0100, 16'h0000);
        wr(1, 8'h13);
        rst_n = 0;
        step(2);
        rst_n = 1;
        chk(16'hffff, 16'hf000);
        report_and_stop;
    end
endmodule // upmc_usb_power_mode_control_test
bind upmc_usb_power_mode_control upmc_properties upmc_properties_i (.*);
